// *** verilog/avr_pkg.sv ***
`default_nettype none
package avr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_TARGET = 8'h04;
	localparam logic [7:0] OFF_WIN1   = 8'h08;
	localparam logic [7:0] OFF_WIN2   = 8'h0C;
	localparam logic [7:0] OFF_INST   = 8'h10;
	localparam logic [7:0] OFF_UVB    = 8'h14;
	localparam logic [7:0] OFF_OC     = 8'h18;
	localparam logic [7:0] OFF_T1     = 8'h1C;
	localparam logic [7:0] OFF_T2     = 8'h20;
	localparam logic [7:0] OFF_GAP    = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;
	localparam logic [7:0] OFF_DEV    = 8'h2C;
	localparam logic [7:0] OFF_ACC    = 8'h30;
	// Control field positions
	localparam int CTRL_EN  = 0;
	localparam int CTRL_INV = 1;
	localparam int CTRL_SEL = 2;
	// Measurement time base and timing defaults
	localparam int TICK_MS    = 5;
	localparam int T1_RST_S   = 60;
	localparam int T2_RST_S   = 40;
	localparam int GAP_RST_MS = 1000;
	localparam logic [15:0] T1_RST  = 16'(T1_RST_S * 1000 / TICK_MS);
	localparam logic [15:0] T2_RST  = 16'(T2_RST_S * 1000 / TICK_MS);
	localparam logic [15:0] GAP_RST = 16'(GAP_RST_MS / TICK_MS);
	// Reset values, voltages in 0.01 %Un
	localparam logic [3:0]  CTRL_RST   = 4'h3;
	localparam logic [15:0] TARGET_RST = 16'h2710;
	localparam logic [15:0] WIN1_RST   = 16'h0064;
	localparam logic [15:0] WIN2_RST   = 16'h010B;
	localparam logic [15:0] INST_RST   = 16'h0341;
	localparam logic [15:0] UVB_RST    = 16'h05DC;
	localparam logic [15:0] OC_RST     = 16'h0000;
	// Percent scale and 3 % drop-out hysteresis
	localparam logic [23:0] PCT     = 24'h000064;
	localparam logic [23:0] HYST_DO = 24'h000061;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

	typedef struct packed {
		logic        valid;
		logic [15:0] u1;
		logic [15:0] u2;
		logic [15:0] u3;
		logic [15:0] u4;
		logic [15:0] i1;
		logic [15:0] i2;
		logic [15:0] i3;
	} avr_meas_t;

	typedef struct packed {
		logic [3:0]  ctrl;
		logic [15:0] target, win1, win2, inst, uvb, oc, t1, t2, gap;
		logic        aw_rdy, aw_have, w_rdy, w_have, bvalid, ar_rdy, rvalid;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata;
		logic        ext_s1, ext_s2;
		logic        pick1, fast, blocked, uv_blk, oc_blk;
		logic signed [16:0] dev;
		logic [31:0] acc;
		logic [15:0] gap_cnt;
		logic        raise, lower;
	} avr_state_t;
endpackage
`default_nettype wire

// *** verilog/avr_regulator.sv ***
// Behaviour
// R1 - Operating-time counting begins once voltage leaves the active window either way.
// R2 - One tap command once voltage stays outside for the full operating time.
// R3 - Counter clears when voltage returns inside window before time expires.
// R4 - First-window pick-up drops out with 3 % hysteresis.
// R5 - All limits are offsets from the current target voltage.
// R6 - Fast window runs inverse or definite time, selectable.
// R7 - Inverse time equals fast delay divided by deviation in percent.
// R8 - Inverse applies beyond second window; first window uses definite time.
// R9 - Above instant threshold, lower at every allowed pulse interval.
// R10 - Below instant threshold, commands follow the window characteristic again.
// R11 - Commands inhibited while voltage is below undervoltage blocking level.
// R12 - Overcurrent from own check or external pick-up blocks regulation.
// R13 - Uses fundamental line-to-line voltages and fundamental phase currents.
// R14 - Measurements are taken on a 5 ms update tick.
// R15 - Configurer sets first window to 1.2 times tap step.
// R16 - Configurer splits first window equally above and below target.
// R17 - Configurer keeps first window at least 5 % above tap step.
// R18 - Configurer makes second window wider than one tap step reach.
// R19 - Configurer sets first-window time typically 30 to 120 s.
// R20 - Configurer sets instant threshold to max overvoltage minus tap step.
// R21 - Configurer sets undervoltage block to all raise positions combined.
// R22 - Supervised voltage selectable among four inputs, default first pair.
// R23 - Raise when below window, lower when above.
`timescale 1ns/1ps
`default_nettype none
module avr_regulator (
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	input  wire avr_pkg::avr_meas_t i_meas,
	input  wire logic              i_ext_oc_pick,
	input  wire logic [7:0]        i_s_axi_awaddr,
	input  wire logic              i_s_axi_awvalid,
	output logic                   o_s_axi_awready,
	input  wire logic [31:0]       i_s_axi_wdata,
	input  wire logic [3:0]        i_s_axi_wstrb,
	input  wire logic              i_s_axi_wvalid,
	output logic                   o_s_axi_wready,
	output logic [1:0]             o_s_axi_bresp,
	output logic                   o_s_axi_bvalid,
	input  wire logic              i_s_axi_bready,
	input  wire logic [7:0]        i_s_axi_araddr,
	input  wire logic              i_s_axi_arvalid,
	output logic                   o_s_axi_arready,
	output logic [31:0]            o_s_axi_rdata,
	output logic [1:0]             o_s_axi_rresp,
	output logic                   o_s_axi_rvalid,
	input  wire logic              i_s_axi_rready,
	output logic                   o_raise,
	output logic                   o_lower
);
	avr_pkg::avr_state_t st;
	avr_pkg::avr_state_t next_st;

	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] u_sel;
	logic signed [16:0] dev;
	logic [15:0] adev;
	logic        tick, over1, under_hyst, fast, inst, uv, oc, blk, pick, fire;
	logic [31:0] tgt, acc_new;
	logic [7:0]  wa, ra;
	logic        wok, rok;

	always_comb begin
		next_st = st;
		u_sel = 16'h0000;
		dev = 17'sh0;
		adev = 16'h0000;
		tick = 1'b0;
		over1 = 1'b0;
		under_hyst = 1'b0;
		fast = 1'b0;
		inst = 1'b0;
		uv = 1'b0;
		oc = 1'b0;
		blk = 1'b0;
		pick = 1'b0;
		fire = 1'b0;
		tgt = 32'h0;
		acc_new = 32'h0;
		wa = 8'h00;
		ra = 8'h00;
		wok = 1'b1;
		rok = 1'b1;
		next_st.ext_s1 = i_ext_oc_pick;
		next_st.ext_s2 = st.ext_s1;
		next_st.raise = 1'b0;
		next_st.lower = 1'b0;

		// Write channel: address and data taken in either order
		if (st.bvalid && i_s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.aw_rdy && i_s_axi_awvalid) begin
			next_st.aw_have = 1'b1;
			next_st.aw_addr = i_s_axi_awaddr;
		end
		if (st.w_rdy && i_s_axi_wvalid) begin
			next_st.w_have = 1'b1;
			next_st.w_data = i_s_axi_wdata;
			next_st.w_strb = i_s_axi_wstrb;
		end
		if (next_st.aw_have && next_st.w_have) begin
			wa = {next_st.aw_addr[7:2], 2'b00};
			case (wa)
				avr_pkg::OFF_CTRL: begin
					if (next_st.w_strb[0]) begin
						next_st.ctrl = next_st.w_data[3:0];
					end
				end
				avr_pkg::OFF_TARGET: next_st.target = wr16(st.target, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_WIN1:   next_st.win1 = wr16(st.win1, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_WIN2:   next_st.win2 = wr16(st.win2, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_INST:   next_st.inst = wr16(st.inst, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_UVB:    next_st.uvb = wr16(st.uvb, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_OC:     next_st.oc = wr16(st.oc, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_T1:     next_st.t1 = wr16(st.t1, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_T2:     next_st.t2 = wr16(st.t2, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_GAP:    next_st.gap = wr16(st.gap, next_st.w_data, next_st.w_strb);
				avr_pkg::OFF_STATUS, avr_pkg::OFF_DEV, avr_pkg::OFF_ACC: wok = 1'b1;
				default: wok = 1'b0;
			endcase
			next_st.aw_have = 1'b0;
			next_st.w_have = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wok ? avr_pkg::RESP_OK : avr_pkg::RESP_ERR;
		end
		next_st.aw_rdy = !next_st.aw_have && !next_st.bvalid;
		next_st.w_rdy = !next_st.w_have && !next_st.bvalid;

		// Read channel, data captured at address acceptance
		if (st.rvalid && i_s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (st.ar_rdy && i_s_axi_arvalid) begin
			ra = {i_s_axi_araddr[7:2], 2'b00};
			next_st.rdata = 32'h0;
			case (ra)
				avr_pkg::OFF_CTRL:   next_st.rdata = {28'h0, st.ctrl};
				avr_pkg::OFF_TARGET: next_st.rdata = {16'h0, st.target};
				avr_pkg::OFF_WIN1:   next_st.rdata = {16'h0, st.win1};
				avr_pkg::OFF_WIN2:   next_st.rdata = {16'h0, st.win2};
				avr_pkg::OFF_INST:   next_st.rdata = {16'h0, st.inst};
				avr_pkg::OFF_UVB:    next_st.rdata = {16'h0, st.uvb};
				avr_pkg::OFF_OC:     next_st.rdata = {16'h0, st.oc};
				avr_pkg::OFF_T1:     next_st.rdata = {16'h0, st.t1};
				avr_pkg::OFF_T2:     next_st.rdata = {16'h0, st.t2};
				avr_pkg::OFF_GAP:    next_st.rdata = {16'h0, st.gap};
				avr_pkg::OFF_STATUS: next_st.rdata = {11'h0, st.gap_cnt == 16'h0000,
					st.pick1, st.fast, st.blocked, st.uv_blk, st.oc_blk, st.gap_cnt[10:0],
					st.ext_s2, 3'h0};
				avr_pkg::OFF_DEV:    next_st.rdata = {{15{st.dev[16]}}, st.dev};
				avr_pkg::OFF_ACC:    next_st.rdata = st.acc;
				default:             rok = 1'b0;
			endcase
			next_st.rvalid = 1'b1;
			next_st.rresp = rok ? avr_pkg::RESP_OK : avr_pkg::RESP_ERR;
		end
		next_st.ar_rdy = !next_st.rvalid;

		////////////////////////////////////////////////////////////////////////
		// Regulation, evaluated once per measurement update
		tick = i_meas.valid; // [R14]
		case (st.ctrl[avr_pkg::CTRL_SEL +: 2]) // [R22] [R13]
			2'h1:    u_sel = i_meas.u2;
			2'h2:    u_sel = i_meas.u3;
			2'h3:    u_sel = i_meas.u4;
			default: u_sel = i_meas.u1;
		endcase
		dev = $signed({1'b0, u_sel}) - $signed({1'b0, st.target}); // [R5]
		adev = dev[16] ? 16'(-dev) : dev[15:0];
		over1 = adev > st.win1;
		// Drop-out below 97 % of the pick-up, avoids chatter at the edge
		under_hyst = (24'(adev) * avr_pkg::PCT) < (24'(st.win1) * avr_pkg::HYST_DO); // [R4]
		pick = over1 ? 1'b1 : (under_hyst ? 1'b0 : st.pick1); // [R1]
		fast = adev > st.win2; // [R8]
		inst = dev > $signed({1'b0, st.inst}); // [R9]
		uv = ({1'b0, u_sel} + {1'b0, st.uvb}) < {1'b0, st.target}; // [R11]
		oc = (st.oc != 16'h0000) && (i_meas.i1 > st.oc || i_meas.i2 > st.oc
			|| i_meas.i3 > st.oc); // [R12] [R13]
		blk = uv || oc || st.ext_s2 || !st.ctrl[avr_pkg::CTRL_EN]; // [R12]
		// Inverse mode adds |dev| per tick against delay*100, so no divider is needed
		tgt = 32'(fast ? st.t2 : st.t1) * 32'(avr_pkg::PCT); // [R7]
		acc_new = (fast != st.fast ? 32'h0 : st.acc)
			+ ((fast && st.ctrl[avr_pkg::CTRL_INV]) ? 32'(adev) : 32'(avr_pkg::PCT)); // [R6] [R7]
		if (tick) begin
			next_st.dev = dev;
			next_st.uv_blk = uv;
			next_st.oc_blk = oc;
			next_st.blocked = blk;
			next_st.pick1 = pick;
			next_st.fast = fast;
			if (st.gap_cnt != 16'h0000) begin
				next_st.gap_cnt = st.gap_cnt - 16'h0001;
			end
			if (blk) begin
				next_st.acc = 32'h0; // [R11] [R12]
			end else if (inst) begin
				next_st.acc = 32'h0;
				fire = st.gap_cnt == 16'h0000; // [R9] [R10]
			end else if (!pick) begin
				next_st.acc = 32'h0; // [R3]
			end else if (acc_new >= tgt) begin
				// Held at the limit while the pulse gap runs out
				next_st.acc = tgt;
				fire = st.gap_cnt == 16'h0000; // [R2] [R10]
			end else begin
				next_st.acc = acc_new; // [R1]
			end
			if (fire) begin
				next_st.acc = 32'h0;
				next_st.gap_cnt = st.gap;
				next_st.raise = dev[16]; // [R23]
				next_st.lower = !dev[16]; // [R23]
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
			st.ctrl <= avr_pkg::CTRL_RST;
			st.target <= avr_pkg::TARGET_RST;
			st.win1 <= avr_pkg::WIN1_RST;
			st.win2 <= avr_pkg::WIN2_RST;
			st.inst <= avr_pkg::INST_RST;
			st.uvb <= avr_pkg::UVB_RST;
			st.oc <= avr_pkg::OC_RST;
			st.t1 <= avr_pkg::T1_RST;
			st.t2 <= avr_pkg::T2_RST;
			st.gap <= avr_pkg::GAP_RST;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_s_axi_awready = st.aw_rdy;
	assign o_s_axi_wready  = st.w_rdy;
	assign o_s_axi_bvalid  = st.bvalid;
	assign o_s_axi_bresp   = st.bresp;
	assign o_s_axi_arready = st.ar_rdy;
	assign o_s_axi_rvalid  = st.rvalid;
	assign o_s_axi_rdata   = st.rdata;
	assign o_s_axi_rresp   = st.rresp;
	assign o_raise         = st.raise;
	assign o_lower         = st.lower;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	sequence s_aw_take;
		i_ce && st.aw_rdy && i_s_axi_awvalid;
	endsequence
	sequence s_w_take;
		i_ce && st.w_rdy && i_s_axi_wvalid;
	endsequence

	write_resp_a: assert property ((s_aw_take and s_w_take) |=> st.bvalid)
		else $error("write not answered");
	read_hold_a: assert property (st.rvalid && !i_s_axi_rready |=> st.rvalid)
		else $error("read data dropped");
	cmd_excl_a: assert property (!(o_raise && o_lower)) // [R23]
		else $error("raise and lower together");
	cmd_pulse_a: assert property (o_raise && i_ce |=> !o_raise)
		else $error("raise longer than one cycle");
	cmd_dir_a: assert property (o_raise |-> st.dev < 0 && !(o_lower)) // [R23]
		else $error("raise while above target");
	block_cmd_a: assert property ((o_raise || o_lower) |-> !st.blocked) // [R12]
		else $error("command while blocked");
	uv_block_a: assert property (st.uv_blk |-> st.blocked && st.acc == 32'h0) // [R11]
		else $error("undervoltage not blocking");
	drop_clear_a: assert property (!st.pick1 |-> st.acc == 32'h0) // [R3]
		else $error("counter kept after drop-out");
	gap_load_a: assert property ((o_raise || o_lower) |-> st.gap_cnt == st.gap) // [R9]
		else $error("pulse gap not loaded");
	hyst_hold_a: assert property (st.pick1 && i_ce && i_meas.valid && !blk // [R4]
		&& !under_hyst |=> st.pick1)
		else $error("pick-up lost inside hysteresis");

	// Per-tick outcomes, seen one cycle after the measurement edge
	sequence s_tick;
		i_ce && i_meas.valid;
	endsequence

	pick_set_a: assert property (s_tick ##0 over1 |=> st.pick1) // [R1]
		else $error("pick-up not set outside window");
	inst_lower_a: assert property (s_tick ##0 (inst && !blk // [R9]
		&& st.gap_cnt == 16'h0000) |=> o_lower)
		else $error("instant lower not issued");
	gap_wait_a: assert property (s_tick ##0 (st.gap_cnt != 16'h0000) // [R9] [R10]
		|=> !o_raise && !o_lower)
		else $error("command inside pulse gap");
	block_clear_a: assert property (s_tick ##0 blk |=> st.acc == 32'h0 // [R11] [R12]
		&& !o_raise && !o_lower)
		else $error("counter or command while blocked");
	ext_block_a: assert property (s_tick ##0 st.ext_s2 |=> st.blocked) // [R12]
		else $error("external pick-up not blocking");
	fire_clear_a: assert property ((o_raise || o_lower) |-> st.acc == 32'h0) // [R2]
		else $error("counter not cleared on command");
endmodule
`default_nettype wire

// *** dv/avr_tap_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module avr_tap_model #(
	parameter int TICK = 20
) (
	input  wire logic          i_mclk,
	input  wire logic          i_rst_n,
	input  wire logic [15:0]   i_volt,
	input  wire logic [15:0]   i_cur,
	input  wire logic          i_raise,
	input  wire logic          i_lower,
	output var avr_pkg::avr_meas_t o_meas,
	output var int             o_nraise,
	output var int             o_nlower
);
	int cnt;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 0;
			o_meas <= '0;
			o_nraise <= 0;
			o_nlower <= 0;
		end else begin
			cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
			o_meas.valid <= (cnt == TICK - 1);
			o_meas.u1 <= i_volt;
			// Unselected channels differ so a wrong select shows
			o_meas.u2 <= ~i_volt;
			o_meas.u3 <= ~i_volt;
			o_meas.u4 <= ~i_volt;
			o_meas.i1 <= i_cur;
			o_meas.i2 <= 16'h0000;
			o_meas.i3 <= 16'h0000;
			o_nraise <= o_nraise + int'(i_raise);
			o_nlower <= o_nlower + int'(i_lower);
		end
	end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                i_mclk = 1'b0;
	logic                i_rst_n = 1'b0;
	logic                ext = 1'b0;
	logic [15:0]         volt = 16'h2710;
	logic [15:0]         cur = 16'h0000;
	logic [7:0]          awaddr = 8'h00;
	logic [7:0]          araddr = 8'h00;
	logic [31:0]         wdata = 32'h00000000;
	logic                awvalid = 1'b0;
	logic                wvalid = 1'b0;
	logic                bready = 1'b0;
	logic                arvalid = 1'b0;
	logic                rready = 1'b0;
	logic                awready, wready, bvalid, arready, rvalid, raise, lower;
	logic [1:0]          bresp, rresp;
	logic [31:0]         rdata, rd_val;
	avr_pkg::avr_meas_t  meas;
	int                  nraise, nlower, err_total, check_count, cyc, tgt;

	always #5 i_mclk = ~i_mclk;

	avr_tap_model i_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_volt(volt), .i_cur(cur),
		.i_raise(raise), .i_lower(lower), .o_meas(meas), .o_nraise(nraise), .o_nlower(nlower));

	avr_regulator i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_meas(meas),
		.i_ext_oc_pick(ext), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
		.i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.o_raise(raise), .o_lower(lower));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("FAIL %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge i_mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", 32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge i_mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd_val = rdata;
		chk("rresp", 32'(rresp), 32'(er));
	endtask

	// Holds target plus dv for exactly n ticks, then compares command counts.
	// Called a few cycles after a tick, so the next tick already sees the new
	// voltage; waiting for a tick first would leak one extra old-voltage tick.
	task automatic run(input int dv, input int n, input int er, input int el);
		int r0;
		int l0;
		@(posedge i_mclk);
		volt <= 16'(tgt + dv);
		r0 = nraise;
		l0 = nlower;
		repeat (n) @(posedge i_mclk iff meas.valid);
		repeat (3) @(posedge i_mclk);
		chk("raise count", 32'(nraise - r0), 32'(er));
		chk("lower count", 32'(nlower - l0), 32'(el));
		$display("test dev %0d ticks %0d done", dv, n);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Whole run needs under two thousand cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		tgt = 32'h2710;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rd(avr_pkg::OFF_CTRL, avr_pkg::RESP_OK);
		chk("ctrl reset", rd_val, 32'h00000003);
		rd(avr_pkg::OFF_TARGET, avr_pkg::RESP_OK);
		chk("target reset", rd_val, 32'h00002710);
		rd(8'h40, avr_pkg::RESP_ERR);
		chk("unmapped data", rd_val, 32'h00000000);
		wr(8'h40, 32'h00000001, avr_pkg::RESP_ERR);
		wr(avr_pkg::OFF_STATUS, 32'h00000001, avr_pkg::RESP_OK);
		rd(avr_pkg::OFF_T1, avr_pkg::RESP_OK);
		chk("t1 reset", rd_val, 32'(avr_pkg::T1_RST));
		wr(avr_pkg::OFF_WIN1, 32'h00000064, avr_pkg::RESP_OK);
		wr(avr_pkg::OFF_WIN2, 32'h0000010B, avr_pkg::RESP_OK);
		wr(avr_pkg::OFF_INST, 32'h00000341, avr_pkg::RESP_OK);
		wr(avr_pkg::OFF_UVB, 32'h000005DC, avr_pkg::RESP_OK);
		wr(avr_pkg::OFF_T1, 32'h00000003, avr_pkg::RESP_OK);
		wr(avr_pkg::OFF_T2, 32'h00000004, avr_pkg::RESP_OK);
		wr(avr_pkg::OFF_GAP, 32'h00000001, avr_pkg::RESP_OK);
		rd(avr_pkg::OFF_T1, avr_pkg::RESP_OK);
		chk("t1 readback", rd_val, 32'h00000003);
		run(0, 2, 0, 0);
		run(101, 3, 0, 1);
		run(0, 2, 0, 0);
		run(-101, 3, 1, 0);
		run(0, 2, 0, 0);
		run(101, 2, 0, 0);
		run(96, 1, 0, 0);
		run(101, 2, 0, 0);
		run(101, 1, 0, 1);
		run(0, 2, 0, 0);
		run(101, 2, 0, 0);
		run(98, 1, 0, 1);
		run(0, 2, 0, 0);
		run(400, 1, 0, 1);
		run(0, 2, 0, 0);
		wr(avr_pkg::OFF_CTRL, 32'h00000001, avr_pkg::RESP_OK);
		run(400, 3, 0, 0);
		run(400, 1, 0, 1);
		wr(avr_pkg::OFF_CTRL, 32'h00000003, avr_pkg::RESP_OK);
		run(0, 2, 0, 0);
		run(900, 1, 0, 1);
		run(0, 2, 0, 0);
		run(-1501, 4, 0, 0);
		rd(avr_pkg::OFF_STATUS, avr_pkg::RESP_OK);
		chk("status uv block", rd_val, 32'h001F0000);
		rd(avr_pkg::OFF_DEV, avr_pkg::RESP_OK);
		chk("deviation", rd_val, 32'hFFFFFA23);
		run(0, 2, 0, 0);
		ext <= 1'b1;
		run(101, 3, 0, 0);
		ext <= 1'b0;
		run(0, 2, 0, 0);
		wr(avr_pkg::OFF_OC, 32'h00000100, avr_pkg::RESP_OK);
		cur <= 16'h0200;
		run(101, 3, 0, 0);
		cur <= 16'h0000;
		run(101, 3, 0, 1);
		run(0, 2, 0, 0);
		tgt = 32'h2800;
		wr(avr_pkg::OFF_TARGET, 32'h00002800, avr_pkg::RESP_OK);
		run(0, 2, 0, 0);
		run(101, 3, 0, 1);
		run(0, 2, 0, 0);
		wr(avr_pkg::OFF_CTRL, 32'h00000007, avr_pkg::RESP_OK);
		run(0, 1, 0, 1);
		end_of_test();
	end
endmodule
`default_nettype wire
